/* hdl/gpp_defines.svh */
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH

// Byte offsets inside one port's register window.
`define GPP_OFF_DIRECTION   12'h400
`define GPP_OFF_IRQ_SENSE   12'h404
`define GPP_OFF_IRQ_BOTH    12'h408
`define GPP_OFF_IRQ_POL     12'h40C
`define GPP_OFF_IRQ_MASK    12'h410
`define GPP_OFF_IRQ_RAW     12'h414
`define GPP_OFF_IRQ_MSK_ST  12'h418
`define GPP_OFF_IRQ_CLEAR   12'h41C
`define GPP_OFF_ALT_FUNC    12'h420
`define GPP_OFF_DRIVE_LOW   12'h500
`define GPP_OFF_DRIVE_MID   12'h504
`define GPP_OFF_DRIVE_HIGH  12'h508
`define GPP_OFF_OPEN_DRAIN  12'h50C
`define GPP_OFF_PULL_UP     12'h510
`define GPP_OFF_PULL_DOWN   12'h514
`define GPP_OFF_SLEW        12'h518
`define GPP_OFF_DIG_EN      12'h51C
`define GPP_OFF_UNLOCK_KEY  12'h520
`define GPP_OFF_COMMIT      12'h524

// Identification words occupy the top twelve words of the window.
`define GPP_ID_TOP_BITS     6'h3F
`define GPP_ID_FIRST_WORD   4'h4

// Pin value register spans the lowest 256 words; address bits 9:2 mask it.
`define GPP_DATA_REGION     2'h0
`define GPP_MASK_LSB        2
`define GPP_MASK_MSB        9

// Reset values of the ordinary registers.
`define GPP_RST_ZERO        8'h00
`define GPP_RST_DRIVE_LOW   8'hFF
`define GPP_RST_LOCKED      1'b1

// Key that opens the commit lock; any other written value closes it.
`define GPP_UNLOCK_KEY      32'h0C0F_FEE5

`endif

/* hdl/gpp_pkg.sv */
package gpp_pkg;
  typedef logic [7:0]  gpp_byte_t;
  typedef logic [11:0] gpp_addr_t;
  typedef logic [31:0] gpp_word_t;
endpackage

/* hdl/gpp_port.sv */
`timescale 1ns/1ps
`include "gpp_defines.svh"

module gpp_port #(
  parameter logic [7:0]  PROTECT_MASK = 8'h00,
  // Identification bytes; the value is arbitrary.
  parameter logic [95:0] IDENT_BYTES  = 96'h0C_0B_0A_09_08_07_06_05_04_03_02_01
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire gpp_pkg::gpp_addr_t i_addr,
  input  wire gpp_pkg::gpp_word_t i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output gpp_pkg::gpp_word_t     o_rdata,
  input  wire gpp_pkg::gpp_byte_t i_pad_in,
  output gpp_pkg::gpp_byte_t     o_pad_out,
  output gpp_pkg::gpp_byte_t     o_pad_oe_n,
  input  wire gpp_pkg::gpp_byte_t i_alt_out,
  input  wire gpp_pkg::gpp_byte_t i_alt_oe,
  output gpp_pkg::gpp_byte_t     o_alt_in,
  output gpp_pkg::gpp_byte_t     o_drive_low,
  output gpp_pkg::gpp_byte_t     o_drive_mid,
  output gpp_pkg::gpp_byte_t     o_drive_high,
  output gpp_pkg::gpp_byte_t     o_open_drain,
  output gpp_pkg::gpp_byte_t     o_pull_up,
  output gpp_pkg::gpp_byte_t     o_pull_down,
  output gpp_pkg::gpp_byte_t     o_slew,
  output gpp_pkg::gpp_byte_t     o_digital_en,
  output logic                   o_irq
);
  import gpp_pkg::*;

  gpp_byte_t pin_value_q;
  gpp_byte_t direction_select_q;
  gpp_byte_t irq_sense_select_q;
  gpp_byte_t irq_both_edges_select_q;
  gpp_byte_t irq_polarity_select_q;
  gpp_byte_t irq_mask_q;
  gpp_byte_t irq_latch_q;
  gpp_byte_t alt_function_select_q;
  gpp_byte_t drive_low_select_q;
  gpp_byte_t drive_mid_select_q;
  gpp_byte_t drive_high_select_q;
  gpp_byte_t open_drain_select_q;
  gpp_byte_t pull_up_select_q;
  gpp_byte_t pull_down_select_q;
  gpp_byte_t slew_control_select_q;
  gpp_byte_t digital_input_enable_q;
  gpp_byte_t commit_permit_q;
  logic      locked_q;
  gpp_byte_t in_meta_q;
  gpp_byte_t in_sync_q;
  gpp_byte_t in_prev_q;
  gpp_word_t rdata_q;
  gpp_word_t rdata_d;

  gpp_byte_t data_mask;
  logic      data_sel;
  gpp_byte_t rise;
  gpp_byte_t fall;
  gpp_byte_t edge_hit;
  gpp_byte_t level_hit;
  gpp_byte_t irq_raw_status;
  gpp_byte_t irq_masked_status;
  gpp_byte_t irq_clear;
  gpp_byte_t commit_ok;
  gpp_byte_t in_digital;
  logic      id_sel;
  logic [3:0] id_idx;

  function automatic logic wr_at(input gpp_addr_t off);
    wr_at = i_wr && (i_addr == off);
  endfunction

  // Data accesses decode the region and word alignment; address bits 9:2 are a mask.
  assign data_sel  = (i_addr[11:10] == `GPP_DATA_REGION) &&
                     (i_addr[1:0] == 2'h0);
  assign data_mask = i_addr[`GPP_MASK_MSB:`GPP_MASK_LSB];
  assign id_sel    = (i_addr[11:6] == `GPP_ID_TOP_BITS) &&
                     (i_addr[5:2] >= `GPP_ID_FIRST_WORD) &&
                     (i_addr[1:0] == 2'h0);
  assign id_idx    = i_addr[5:2] - `GPP_ID_FIRST_WORD;

  // The first stage is read only by the second, never by logic.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      in_meta_q <= `GPP_RST_ZERO;
      in_sync_q <= `GPP_RST_ZERO;
      in_prev_q <= `GPP_RST_ZERO;
    end else begin
      in_meta_q <= i_pad_in;
      in_sync_q <= in_meta_q;
      in_prev_q <= in_sync_q;
    end
  end

  // A disabled digital input reads low so a floating pad cannot toggle it.
  assign in_digital = in_sync_q & digital_input_enable_q;
  assign o_alt_in   = in_digital;

  // Input bits follow the pad; output bits keep what software wrote.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_value_q <= `GPP_RST_ZERO;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (!direction_select_q[b]) begin
          pin_value_q[b] <= in_digital[b];
        end else if (i_wr && data_sel && data_mask[b]) begin
          pin_value_q[b] <= i_wdata[b];
        end
      end
    end
  end

  // Each port holds its own full register set.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      direction_select_q      <= `GPP_RST_ZERO;
      irq_sense_select_q      <= `GPP_RST_ZERO;
      irq_both_edges_select_q <= `GPP_RST_ZERO;
      irq_polarity_select_q   <= `GPP_RST_ZERO;
      irq_mask_q              <= `GPP_RST_ZERO;
      drive_low_select_q      <= `GPP_RST_DRIVE_LOW;
      drive_mid_select_q      <= `GPP_RST_ZERO;
      drive_high_select_q     <= `GPP_RST_ZERO;
      open_drain_select_q     <= `GPP_RST_ZERO;
      pull_down_select_q      <= `GPP_RST_ZERO;
      slew_control_select_q   <= `GPP_RST_ZERO;
      pull_up_select_q        <= PROTECT_MASK;
      digital_input_enable_q  <= PROTECT_MASK;
    end else begin
      if (wr_at(`GPP_OFF_DIRECTION)) begin
        direction_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_IRQ_SENSE)) begin
        irq_sense_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_IRQ_BOTH)) begin
        irq_both_edges_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_IRQ_POL)) begin
        irq_polarity_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_IRQ_MASK)) begin
        irq_mask_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_DRIVE_LOW)) begin
        drive_low_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_DRIVE_MID)) begin
        drive_mid_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_DRIVE_HIGH)) begin
        drive_high_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_OPEN_DRAIN)) begin
        open_drain_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_PULL_UP)) begin
        pull_up_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_PULL_DOWN)) begin
        pull_down_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_SLEW)) begin
        slew_control_select_q <= i_wdata[7:0];
      end
      if (wr_at(`GPP_OFF_DIG_EN)) begin
        digital_input_enable_q <= i_wdata[7:0];
      end
    end
  end

  // The lock reopens only on the exact key; any other word closes it.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      locked_q <= `GPP_RST_LOCKED;
    end else if (wr_at(`GPP_OFF_UNLOCK_KEY)) begin
      locked_q <= (i_wdata != `GPP_UNLOCK_KEY);
    end
  end

  // Only protected bits of the commit register are writable, and only open.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      commit_permit_q <= ~PROTECT_MASK;
    end else if (wr_at(`GPP_OFF_COMMIT) && !locked_q) begin
      commit_permit_q <= (commit_permit_q & ~PROTECT_MASK) |
                         (i_wdata[7:0] & PROTECT_MASK);
    end
  end

  assign commit_ok = ~PROTECT_MASK | (commit_permit_q & {8{!locked_q}});

  // Debug pins come up owned by the test port, including test reset.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      alt_function_select_q <= PROTECT_MASK;
    end else if (wr_at(`GPP_OFF_ALT_FUNC)) begin
      alt_function_select_q <= (alt_function_select_q & ~commit_ok) |
                               (i_wdata[7:0] & commit_ok);
    end
  end

  // Rewriting a trigger setting can fire a detector at once, so software
  // must mask the pin first.
  assign rise      = in_sync_q & ~in_prev_q;
  assign fall      = ~in_sync_q & in_prev_q;
  assign edge_hit  = ~irq_sense_select_q &
                     ((irq_both_edges_select_q & (rise | fall)) |
                      (~irq_both_edges_select_q &
                       ((irq_polarity_select_q & rise) |
                        (~irq_polarity_select_q & fall))));
  // Level conditions are not latched and vanish with the level.
  assign level_hit = irq_sense_select_q &
                     ~(in_sync_q ^ irq_polarity_select_q);
  assign irq_clear = wr_at(`GPP_OFF_IRQ_CLEAR) ? i_wdata[7:0]
                                                : `GPP_RST_ZERO;

  // A new edge in the clearing cycle survives the clear.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_latch_q <= `GPP_RST_ZERO;
    end else begin
      irq_latch_q <= (irq_latch_q & ~irq_clear) | edge_hit;
    end
  end

  assign irq_raw_status    = irq_latch_q | level_hit;
  assign irq_masked_status = irq_raw_status & irq_mask_q;
  assign o_irq             = |irq_masked_status;

  // Pad output path; open drain only ever pulls low.
  for (genvar g = 0; g < 8; g++) begin : g_pad
    logic drive_en;
    logic drive_val;
    assign drive_en  = digital_input_enable_q[g] &
                       (alt_function_select_q[g] ? i_alt_oe[g]
                                                 : direction_select_q[g]);
    assign drive_val = alt_function_select_q[g] ? i_alt_out[g]
                                                : pin_value_q[g];
    assign o_pad_out[g]  = open_drain_select_q[g] ? 1'b0 : drive_val;
    assign o_pad_oe_n[g] = ~(drive_en &
                             (~open_drain_select_q[g] | ~drive_val));
  end

  assign o_drive_low  = drive_low_select_q;
  assign o_drive_mid  = drive_mid_select_q;
  assign o_drive_high = drive_high_select_q;
  assign o_open_drain = open_drain_select_q;
  assign o_pull_up    = pull_up_select_q;
  assign o_pull_down  = pull_down_select_q;
  assign o_slew       = slew_control_select_q;
  assign o_digital_en = digital_input_enable_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (data_sel) begin
      rdata_d[7:0] = pin_value_q & data_mask;
    end else if (id_sel) begin
      rdata_d[7:0] = IDENT_BYTES[id_idx*8 +: 8];
    end else begin
      case (i_addr)
        `GPP_OFF_DIRECTION:  rdata_d[7:0] = direction_select_q;
        `GPP_OFF_IRQ_SENSE:  rdata_d[7:0] = irq_sense_select_q;
        `GPP_OFF_IRQ_BOTH:   rdata_d[7:0] = irq_both_edges_select_q;
        `GPP_OFF_IRQ_POL:    rdata_d[7:0] = irq_polarity_select_q;
        `GPP_OFF_IRQ_MASK:   rdata_d[7:0] = irq_mask_q;
        `GPP_OFF_IRQ_RAW:    rdata_d[7:0] = irq_raw_status;
        `GPP_OFF_IRQ_MSK_ST: rdata_d[7:0] = irq_masked_status;
        `GPP_OFF_ALT_FUNC:   rdata_d[7:0] = alt_function_select_q;
        `GPP_OFF_DRIVE_LOW:  rdata_d[7:0] = drive_low_select_q;
        `GPP_OFF_DRIVE_MID:  rdata_d[7:0] = drive_mid_select_q;
        `GPP_OFF_DRIVE_HIGH: rdata_d[7:0] = drive_high_select_q;
        `GPP_OFF_OPEN_DRAIN: rdata_d[7:0] = open_drain_select_q;
        `GPP_OFF_PULL_UP:    rdata_d[7:0] = pull_up_select_q;
        `GPP_OFF_PULL_DOWN:  rdata_d[7:0] = pull_down_select_q;
        `GPP_OFF_SLEW:       rdata_d[7:0] = slew_control_select_q;
        `GPP_OFF_DIG_EN:     rdata_d[7:0] = digital_input_enable_q;
        `GPP_OFF_UNLOCK_KEY: rdata_d[0]   = locked_q;
        `GPP_OFF_COMMIT:     rdata_d[7:0] = commit_permit_q;
        default:             rdata_d      = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= i_rd ? rdata_d : 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_q;

  a_reset_defaults: assert property (
    @(posedge i_clk) $fell(i_rst) |->
      (alt_function_select_q == PROTECT_MASK) &&
      (digital_input_enable_q == PROTECT_MASK) &&
      (pull_up_select_q == PROTECT_MASK) &&
      (pull_down_select_q == 8'h00) &&
      ((o_pad_oe_n & ~PROTECT_MASK) == ~PROTECT_MASK))
    else $error("pins not in reset configuration");

  a_data_write_mask: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && data_sel) |=>
      (((pin_value_q ^ $past(pin_value_q)) &
        $past(direction_select_q) & ~$past(data_mask)) == 8'h00) &&
      (((pin_value_q ^ $past(i_wdata[7:0])) &
        $past(direction_select_q) & $past(data_mask)) == 8'h00))
    else $error("masked data write altered wrong bits");

  a_data_read_mask: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && data_sel) |=>
      (o_rdata[7:0] == ($past(pin_value_q) & $past(data_mask))) &&
      (o_rdata[31:8] == 24'h00_0000))
    else $error("data read mask wrong");

  a_input_capture: assert property (
    @(posedge i_clk) disable iff (i_rst)
    1'b1 ##1 1'b1 |->
      (((pin_value_q ^ $past(in_digital)) &
        ~$past(direction_select_q)) == 8'h00))
    else $error("input pin not captured");

  a_latch_holds: assert property (
    @(posedge i_clk) disable iff (i_rst)
    1'b1 ##1 1'b1 |->
      (($past(irq_latch_q) & ~$past(irq_clear) & ~irq_latch_q) == 8'h00))
    else $error("edge latch dropped without clear");

  a_clear_works: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (wr_at(`GPP_OFF_IRQ_CLEAR)) |=>
      ((irq_latch_q & $past(i_wdata[7:0]) & ~$past(edge_hit)) == 8'h00))
    else $error("clear write did not clear latch");

  a_masked_read: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && (i_addr == `GPP_OFF_IRQ_MSK_ST)) |=>
      (o_rdata[7:0] == ($past(irq_raw_status) & $past(irq_mask_q))))
    else $error("masked status read wrong");

  a_irq_combine: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_irq == |(irq_mask_q & (irq_latch_q | (irq_sense_select_q &
               ~(in_sync_q ^ irq_polarity_select_q)))))
    else $error("combined interrupt mismatch");

  a_commit_guard: assert property (
    @(posedge i_clk) disable iff (i_rst)
    wr_at(`GPP_OFF_ALT_FUNC) |=>
      (((alt_function_select_q ^ $past(alt_function_select_q)) &
        PROTECT_MASK & ~($past(commit_permit_q) &
        {8{!$past(locked_q)}})) == 8'h00))
    else $error("protected alternate bit changed while locked");

  a_output_drive: assert property (
    @(posedge i_clk) disable iff (i_rst)
    ((digital_input_enable_q & ~alt_function_select_q &
      direction_select_q & ~open_drain_select_q) & o_pad_oe_n) == 8'h00)
    else $error("output pin not driven");

endmodule // gpp_port

/* verification/gpp_pad_model.sv */
`timescale 1ns/1ps
module gpp_pad_model (
  input  wire logic               i_clk,
  input  wire gpp_pkg::gpp_byte_t i_pad_out,
  input  wire gpp_pkg::gpp_byte_t i_pad_oe_n,
  input  wire gpp_pkg::gpp_byte_t i_pull_up,
  input  wire gpp_pkg::gpp_byte_t i_pull_down,
  input  wire gpp_pkg::gpp_byte_t i_ext_val,
  input  wire gpp_pkg::gpp_byte_t i_ext_en,
  output gpp_pkg::gpp_byte_t      o_pad_level
);
  import gpp_pkg::*;
  gpp_byte_t float_q = 8'h55;
  // A pin nobody drives or pulls wanders, so a stale value never passes.
  always_ff @(posedge i_clk) begin
    float_q <= ~float_q;
  end
  // The outside source holds the level of a pin the port does not drive, until the bench releases it.
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!i_pad_oe_n[b]) begin
        o_pad_level[b] = i_pad_out[b];
      end else if (i_ext_en[b]) begin
        o_pad_level[b] = i_ext_val[b];
      end else if (i_pull_up[b]) begin
        o_pad_level[b] = 1'b1;
      end else if (i_pull_down[b]) begin
        o_pad_level[b] = 1'b0;
      end else begin
        o_pad_level[b] = float_q[b];
      end
    end
  end
endmodule  // gpp_pad_model

/* verification/tb_general_purpose_io_port.sv */
`timescale 1ns/1ps
`include "gpp_defines.svh"
module tb_general_purpose_io_port;
  import gpp_pkg::*;
  localparam gpp_byte_t PMASK = 8'h0F;
  logic      clk;
  logic      rst = 1'b1;
  gpp_addr_t addr = '0;
  gpp_word_t wdata = '0;
  logic      wr = 1'b0;
  logic      rd = 1'b0;
  gpp_word_t rdata;
  gpp_byte_t pad_in, pad_out, pad_oe_n, alt_in;
  gpp_byte_t alt_out = 8'h00;
  gpp_byte_t alt_oe = 8'h00;
  gpp_byte_t ext_val = 8'h00;
  gpp_byte_t ext_en = 8'h00;
  gpp_byte_t dlo, dmid, dhi, odr, pu, pd, slew, den;
  logic      irq;
  int        err_count = 0;
  int        n_checks = 0;

  gpp_port #(.PROTECT_MASK(PMASK)) i_dut (
    .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_pad_in(pad_in), .o_pad_out(pad_out),
    .o_pad_oe_n(pad_oe_n), .i_alt_out(alt_out), .i_alt_oe(alt_oe),
    .o_alt_in(alt_in), .o_drive_low(dlo), .o_drive_mid(dmid),
    .o_drive_high(dhi), .o_open_drain(odr), .o_pull_up(pu),
    .o_pull_down(pd), .o_slew(slew), .o_digital_en(den), .o_irq(irq));

  gpp_pad_model i_pad (
    .i_clk(clk), .i_pad_out(pad_out), .i_pad_oe_n(pad_oe_n),
    .i_pull_up(pu), .i_pull_down(pd), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_pad_level(pad_in));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic fail(gpp_word_t got, gpp_word_t exp);
    err_count++;
    $display("[ERR] %0t got %h expected %h", $time, got, exp);
  endtask
  task automatic chk_word(gpp_word_t got, gpp_word_t exp);
    n_checks++;
    if (got !== exp) fail(got, exp);
  endtask
  task automatic chk_byte(gpp_byte_t got, gpp_byte_t exp);
    n_checks++;
    if (got !== exp) fail({24'h00_0000, got}, {24'h00_0000, exp});
  endtask
  task automatic chk_bit(logic got, logic exp);
    n_checks++;
    if (got !== exp) fail({31'h0, got}, {31'h0, exp});
  endtask

  task automatic bus_wr(gpp_addr_t a, gpp_word_t d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe edge.
  task automatic rd_chk(gpp_addr_t a, gpp_word_t exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_word(rdata, exp);
  endtask
  // Two sync flops plus capture need three edges; four gives margin.
  task automatic set_pad(gpp_byte_t v);
    @(posedge clk);
    ext_val <= v;
    ext_en <= 8'hFF;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    chk_byte(pu, PMASK);
    chk_byte(den, PMASK);
    chk_byte(pd, 8'h00);
    chk_byte(pad_oe_n, 8'hFF);
    chk_byte(dlo, 8'hFF);
    chk_bit(irq, 1'b0);
    rd_chk(`GPP_OFF_ALT_FUNC, {24'h00_0000, PMASK});
    rd_chk(`GPP_OFF_UNLOCK_KEY, 32'h0000_0001);
    rd_chk(`GPP_OFF_COMMIT, {24'h00_0000, ~PMASK});
  endtask

  task automatic t_data;
    bus_wr(`GPP_OFF_DIRECTION, 32'h0000_00FF);
    // Start from a known zero; captured input bits would linger otherwise.
    bus_wr(12'h3FC, 32'h0000_0000);
    bus_wr(`GPP_OFF_DIG_EN, 32'h0000_00FF);
    bus_wr(12'h098, 32'h0000_00EB);
    // Debug bits belong to the idle peripheral, so they stay undriven.
    chk_byte(pad_out, 8'h20);
    chk_byte(pad_oe_n, 8'h0F);
    rd_chk(12'h3FC, 32'h0000_0022);
    rd_chk(12'h0C4, 32'h0000_0020);
    bus_wr(12'h004, 32'h0000_00FF);
    rd_chk(12'h3FC, 32'h0000_0023);
    bus_wr(`GPP_OFF_DIRECTION, 32'h0000_0000);
    chk_byte(pad_oe_n, 8'hFF);
    set_pad(8'hA5);
    rd_chk(12'h3FC, 32'h0000_00A5);
    chk_byte(alt_in, 8'hA5);
  endtask

  task automatic t_irq;
    set_pad(8'h00);
    bus_wr(`GPP_OFF_IRQ_POL, 32'h0000_0004);
    bus_wr(`GPP_OFF_IRQ_CLEAR, 32'h0000_00FF);
    bus_wr(`GPP_OFF_IRQ_MASK, 32'h0000_0004);
    set_pad(8'h0C);
    rd_chk(`GPP_OFF_IRQ_RAW, 32'h0000_0004);
    rd_chk(`GPP_OFF_IRQ_MSK_ST, 32'h0000_0004);
    chk_bit(irq, 1'b1);
    set_pad(8'h00);
    rd_chk(`GPP_OFF_IRQ_RAW, 32'h0000_000C);
    rd_chk(`GPP_OFF_IRQ_MSK_ST, 32'h0000_0004);
    bus_wr(`GPP_OFF_IRQ_CLEAR, 32'h0000_0000);
    rd_chk(`GPP_OFF_IRQ_RAW, 32'h0000_000C);
    bus_wr(`GPP_OFF_IRQ_CLEAR, 32'h0000_0004);
    rd_chk(`GPP_OFF_IRQ_RAW, 32'h0000_0008);
    chk_bit(irq, 1'b0);
    bus_wr(`GPP_OFF_IRQ_MASK, 32'h0000_0000);
    bus_wr(`GPP_OFF_IRQ_BOTH, 32'h0000_0010);
    bus_wr(`GPP_OFF_IRQ_SENSE, 32'h0000_0020);
    bus_wr(`GPP_OFF_IRQ_POL, 32'h0000_0020);
    bus_wr(`GPP_OFF_IRQ_CLEAR, 32'h0000_00FF);
    bus_wr(`GPP_OFF_IRQ_MASK, 32'h0000_0030);
    set_pad(8'h30);
    rd_chk(`GPP_OFF_IRQ_RAW, 32'h0000_0030);
    chk_bit(irq, 1'b1);
    set_pad(8'h00);
    rd_chk(`GPP_OFF_IRQ_RAW, 32'h0000_0010);
    bus_wr(`GPP_OFF_IRQ_CLEAR, 32'h0000_0010);
    chk_bit(irq, 1'b0);
  endtask

  task automatic t_alt;
    bus_wr(`GPP_OFF_ALT_FUNC, 32'h0000_0000);
    rd_chk(`GPP_OFF_ALT_FUNC, {24'h00_0000, PMASK});
    bus_wr(`GPP_OFF_COMMIT, 32'h0000_0001);
    rd_chk(`GPP_OFF_COMMIT, {24'h00_0000, ~PMASK});
    bus_wr(`GPP_OFF_UNLOCK_KEY, `GPP_UNLOCK_KEY);
    rd_chk(`GPP_OFF_UNLOCK_KEY, 32'h0000_0000);
    bus_wr(`GPP_OFF_COMMIT, 32'h0000_0001);
    bus_wr(`GPP_OFF_ALT_FUNC, 32'h0000_0080);
    rd_chk(`GPP_OFF_ALT_FUNC, 32'h0000_008E);
    @(posedge clk);
    alt_oe <= 8'h80;
    alt_out <= 8'h80;
    @(posedge clk);
    #1;
    chk_bit(pad_oe_n[7], 1'b0);
    chk_bit(pad_out[7], 1'b1);
    @(posedge clk);
    alt_oe <= 8'h00;
  endtask

  function automatic gpp_byte_t pad_ctl(int k);
    case (k)
      0: return dlo;
      1: return dmid;
      2: return dhi;
      3: return odr;
      4: return pu;
      5: return pd;
      6: return slew;
      default: return den;
    endcase
  endfunction

  task automatic t_pads;
    for (int k = 0; k < 8; k++) begin
      bus_wr(`GPP_OFF_DRIVE_LOW + 12'(4 * k), 32'h0000_005A);
      chk_byte(pad_ctl(k), 8'h5A);
      rd_chk(`GPP_OFF_DRIVE_LOW + 12'(4 * k), 32'h0000_005A);
    end
    rd_chk(12'h600, 32'h0000_0000);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #100_000;
    err_count++;
    complete_run();
  end

  initial begin
    do_reset();
    t_reset();
    t_data();
    t_irq();
    t_alt();
    t_pads();
    do_reset();
    t_reset();
    complete_run();
  end
endmodule  // tb_general_purpose_io_port
